// >>> verilog/tcb_counter16.sv
// Byte-accessed 16-bit up/down counter with shared high-byte holding register.
`timescale 1ns/1ps
`include "tcb_params.svh"

////////////////////////////////////////////////////////////////////////////////
module tcb_counter16 (
  input wire logic clock,
  input wire logic reset_n,
  input wire tcb_pkg::tcb_bus_t bus,
  input wire logic [3:0] prescaleTick,
  input wire logic extTickPin,
  output logic [7:0] rdData,
  output logic [15:0] countValue,
  output logic atTop,
  output logic atBottom,
  output logic overflowIrq
);

  ////////////////////////////////////////////////////////////////////////////////
  // Reset release through two flip-flops.
  logic rstMeta_q;
  logic rstSync_q;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rstMeta_q <= 1'b0;
      rstSync_q <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstSync_q <= rstMeta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Mode decoding.
  function automatic tcb_pkg::tcb_mode_t decodeMode(input logic [3:0] wgm);
    tcb_pkg::tcb_mode_t m;
    m.topSel = tcb_pkg::TOP_FIXED;
    m.fixedTop = `TCB_MAX;
    m.upDown = 1'b0;
    m.clearAtTop = 1'b0;
    m.ovfSel = tcb_pkg::OVF_AT_MAX;
    case (wgm)
      4'h1, 4'h5: m.fixedTop = `TCB_TOP_8BIT;
      4'h2, 4'h6: m.fixedTop = `TCB_TOP_9BIT;
      4'h3, 4'h7: m.fixedTop = `TCB_TOP_10BIT;
      4'h4, 4'h9, 4'hb, 4'hf: m.topSel = tcb_pkg::TOP_CMPA;
      4'h8, 4'ha, 4'hc, 4'he: m.topSel = tcb_pkg::TOP_CAP;
      default: m.fixedTop = `TCB_MAX;
    endcase
    case (wgm)
      4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'hb: begin
        m.upDown = 1'b1;
        m.ovfSel = tcb_pkg::OVF_AT_BOTTOM;
      end
      4'h5, 4'h6, 4'h7, 4'he, 4'hf: begin
        m.clearAtTop = 1'b1;
        m.ovfSel = tcb_pkg::OVF_AT_TOP;
      end
      4'h4, 4'hc: m.clearAtTop = 1'b1;
      default: m.clearAtTop = 1'b0;
    endcase
    return m;
  endfunction : decodeMode

  ////////////////////////////////////////////////////////////////////////////////
  // Register state.
  logic [15:0] count_q, count_d;
  logic [7:0] temp_q, temp_d;
  logic [7:0] ctrlA_q, ctrlA_d;
  logic [7:0] ctrlB_q, ctrlB_d;
  logic [15:0] cmpA_q, cmpA_d;
  logic [15:0] cmpB_q, cmpB_d;
  logic [15:0] cap_q, cap_d;
  logic ovfFlag_q, ovfFlag_d;
  logic dirDown_q, dirDown_d;
  logic extPrev_q;
  logic [7:0] rdData_q, rdData_d;
  logic atTop_q, atTop_d;
  logic atBottom_q, atBottom_d;

  logic [3:0] wgm;
  logic [2:0] tickSel;
  tcb_pkg::tcb_mode_t mode;
  logic [15:0] topVal;
  logic tick;
  logic cntWrite;
  logic clearNow;
  logic ovfEvent;

  assign wgm = {ctrlB_q[`TCB_CTRLB_WGM_LSB +: 2], ctrlA_q[`TCB_CTRLA_WGM_LSB +: 2]};
  assign tickSel = ctrlB_q[`TCB_CTRLB_CS_LSB +: 3];
  assign mode = decodeMode(wgm);
  assign cntWrite = bus.wr && (bus.addr == `TCB_ADDR_CNT_LO);

  always_comb begin
    case (mode.topSel)
      tcb_pkg::TOP_CMPA: topVal = cmpA_q;
      tcb_pkg::TOP_CAP: topVal = cap_q;
      default: topVal = mode.fixedTop;
    endcase
  end

  // The prescaler lives outside; its taps arrive as one-cycle pulses on the system clock.
  always_comb begin
    case (tickSel)
      3'h0: tick = 1'b0;
      3'h1: tick = 1'b1;
      3'h2: tick = prescaleTick[0];
      3'h3: tick = prescaleTick[1];
      3'h4: tick = prescaleTick[2];
      3'h5: tick = prescaleTick[3];
      3'h6: tick = extPrev_q && !extTickPin;
      3'h7: tick = !extPrev_q && extTickPin;
      default: tick = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic for counter, holding register and control registers.
  always_comb begin
    count_d = count_q;
    dirDown_d = dirDown_q;
    temp_d = temp_q;
    ctrlA_d = ctrlA_q;
    ctrlB_d = ctrlB_q;
    cmpA_d = cmpA_q;
    cmpB_d = cmpB_q;
    cap_d = cap_q;
    ovfFlag_d = ovfFlag_q;
    clearNow = 1'b0;
    ovfEvent = 1'b0;
    rdData_d = 8'h00;

    if (tick) begin
      if (mode.upDown) begin
        if (!dirDown_q && count_q >= topVal) begin
          dirDown_d = 1'b1;
          count_d = 16'(count_q - `TCB_ONE);
        end else if (dirDown_q && count_q == `TCB_RST_WORD) begin
          dirDown_d = 1'b0;
          count_d = 16'(count_q + `TCB_ONE);
          ovfEvent = (mode.ovfSel == tcb_pkg::OVF_AT_BOTTOM);
        end else begin
          count_d = dirDown_q ? 16'(count_q - `TCB_ONE) : 16'(count_q + `TCB_ONE);
        end
      end else if (mode.clearAtTop && count_q == topVal) begin
        clearNow = 1'b1;
        count_d = `TCB_RST_WORD;
        dirDown_d = 1'b0;
        ovfEvent = (mode.ovfSel == tcb_pkg::OVF_AT_TOP) || (count_q == `TCB_MAX);
      end else begin
        count_d = 16'(count_q + `TCB_ONE);
        dirDown_d = 1'b0;
        ovfEvent = (count_q == `TCB_MAX);
      end
    end

    // Reads are served regardless of whether ticks run.
    if (bus.rd) begin
      case (bus.addr)
        `TCB_ADDR_CNT_LO: begin
          rdData_d = count_q[7:0];
          temp_d = count_q[15:8];
        end
        `TCB_ADDR_CNT_HI: rdData_d = temp_q;
        `TCB_ADDR_CTRL_A: rdData_d = ctrlA_q;
        `TCB_ADDR_CTRL_B: rdData_d = ctrlB_q;
        `TCB_ADDR_CMPA_LO: rdData_d = cmpA_q[7:0];
        `TCB_ADDR_CMPA_HI: rdData_d = cmpA_q[15:8];
        `TCB_ADDR_CMPB_LO: rdData_d = cmpB_q[7:0];
        `TCB_ADDR_CMPB_HI: rdData_d = cmpB_q[15:8];
        `TCB_ADDR_CAP_LO: begin
          rdData_d = cap_q[7:0];
          temp_d = cap_q[15:8];
        end
        `TCB_ADDR_CAP_HI: rdData_d = temp_q;
        `TCB_ADDR_STATUS: rdData_d = {7'h00, ovfFlag_q};
        default: rdData_d = 8'h00;
      endcase
    end

    // A write to any upper byte only parks the value; the lower-byte write commits both halves.
    if (bus.wr) begin
      case (bus.addr)
        `TCB_ADDR_CNT_LO: begin
          count_d = {temp_q, bus.data};
          dirDown_d = dirDown_q;
        end
        `TCB_ADDR_CNT_HI, `TCB_ADDR_CMPA_HI, `TCB_ADDR_CMPB_HI, `TCB_ADDR_CAP_HI: begin
          temp_d = bus.data;
        end
        `TCB_ADDR_CTRL_A: ctrlA_d = bus.data;
        `TCB_ADDR_CTRL_B: ctrlB_d = bus.data;
        `TCB_ADDR_CMPA_LO: cmpA_d = {temp_q, bus.data};
        `TCB_ADDR_CMPB_LO: cmpB_d = {temp_q, bus.data};
        `TCB_ADDR_CAP_LO: cap_d = {temp_q, bus.data};
        `TCB_ADDR_STATUS: begin
          if (bus.data[`TCB_STATUS_OVF_BIT]) begin
            ovfFlag_d = 1'b0;
          end
        end
        default: ctrlA_d = ctrlA_q;
      endcase
    end

    // A new overflow in the clearing cycle must not be lost, so the set comes last.
    if (ovfEvent && !cntWrite) begin
      ovfFlag_d = 1'b1;
    end

    atTop_d = (count_d == topVal);
    atBottom_d = (count_d == `TCB_RST_WORD);
  end

  always_ff @(posedge clock or negedge rstSync_q) begin
    if (!rstSync_q) begin
      count_q <= `TCB_RST_WORD;
      temp_q <= `TCB_RST_BYTE;
      ovfFlag_q <= 1'b0;
      dirDown_q <= 1'b0;
      ctrlA_q <= `TCB_RST_BYTE;
      ctrlB_q <= `TCB_RST_BYTE;
      cmpA_q <= `TCB_RST_WORD;
      cmpB_q <= `TCB_RST_WORD;
      cap_q <= `TCB_RST_WORD;
      extPrev_q <= 1'b0;
      rdData_q <= 8'h00;
      atTop_q <= 1'b0;
      atBottom_q <= 1'b1;
    end else begin
      count_q <= count_d;
      temp_q <= temp_d;
      ovfFlag_q <= ovfFlag_d;
      dirDown_q <= dirDown_d;
      ctrlA_q <= ctrlA_d;
      ctrlB_q <= ctrlB_d;
      cmpA_q <= cmpA_d;
      cmpB_q <= cmpB_d;
      cap_q <= cap_d;
      extPrev_q <= extTickPin;
      rdData_q <= rdData_d;
      atTop_q <= atTop_d;
      atBottom_q <= atBottom_d;
    end
  end

  assign rdData = rdData_q;
  assign countValue = count_q;
  assign atTop = atTop_q;
  assign atBottom = atBottom_q;
  assign overflowIrq = ovfFlag_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions.
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstSync_q);

  a_lowbyte_write_load: assert property (
    cntWrite |=> count_q == {$past(temp_q), $past(bus.data)})
    else $error("Counter not loaded from holding register and written byte.");

  a_write_beats_tick: assert property (
    (cntWrite && tick) |=> count_q[7:0] == $past(bus.data))
    else $error("Tick overrode a CPU counter write.");

  a_lowbyte_read_latch: assert property (
    (bus.rd && bus.addr == `TCB_ADDR_CNT_LO && !bus.wr) |=> temp_q == $past(count_q[15:8]))
    else $error("Holding register did not capture counter upper byte.");

  a_highbyte_read_temp: assert property (
    (bus.rd && bus.addr == `TCB_ADDR_CNT_HI) |=> rdData_q == $past(temp_q))
    else $error("Counter upper-byte read did not return holding register.");

  a_cmp_high_direct: assert property (
    (bus.rd && bus.addr == `TCB_ADDR_CMPA_HI && !bus.wr) |=> rdData_q == $past(cmpA_q[15:8]) && $stable(temp_q))
    else $error("Compare upper-byte read touched holding register.");

  a_stopped_holds: assert property (
    (tickSel == 3'h0 && !cntWrite) [*3] |=> $stable(count_q))
    else $error("Counter moved with tick select at zero.");

  a_step_by_one: assert property (
    (tick && !cntWrite && !clearNow) |=> (count_q == 16'($past(count_q) + `TCB_ONE)) ||
      (count_q == 16'($past(count_q) - `TCB_ONE)))
    else $error("Count step was not exactly one.");

  a_clear_to_zero: assert property (
    (tick && clearNow && !cntWrite) |=> count_q == `TCB_RST_WORD ##1 $past(atBottom_q))
    else $error("Clear did not zero the counter.");

  a_bottom_tracks: assert property (
    atBottom_q == (count_q == `TCB_RST_WORD))
    else $error("Bottom indicator disagrees with counter.");

  a_ovf_sets: assert property (
    (ovfEvent && !cntWrite) |=> ovfFlag_q && overflowIrq)
    else $error("Overflow event did not set the flag.");

  a_temp_keeps: assert property (
    !(bus.wr && bus.addr inside {`TCB_ADDR_CNT_HI, `TCB_ADDR_CMPA_HI, `TCB_ADDR_CMPB_HI, `TCB_ADDR_CAP_HI}) &&
      !(bus.rd && bus.addr inside {`TCB_ADDR_CNT_LO, `TCB_ADDR_CAP_LO}) |=> $stable(temp_q))
    else $error("Holding register changed without an access.");

endmodule : tcb_counter16

// >>> verilog/tcb_params.svh
// Address map, field positions, reset values and fixed counts of the byte-accessed 16-bit counter.
`ifndef TCB_PARAMS_SVH
`define TCB_PARAMS_SVH

// Byte locations on the 8-bit register port.
`define TCB_ADDR_CNT_LO 4'h0
`define TCB_ADDR_CNT_HI 4'h1
`define TCB_ADDR_CTRL_A 4'h2
`define TCB_ADDR_CTRL_B 4'h3
`define TCB_ADDR_CMPA_LO 4'h4
`define TCB_ADDR_CMPA_HI 4'h5
`define TCB_ADDR_CMPB_LO 4'h6
`define TCB_ADDR_CMPB_HI 4'h7
`define TCB_ADDR_CAP_LO 4'h8
`define TCB_ADDR_CAP_HI 4'h9
`define TCB_ADDR_STATUS 4'ha

// Field positions.
`define TCB_CTRLA_WGM_LSB 0
`define TCB_CTRLB_CS_LSB 0
`define TCB_CTRLB_WGM_LSB 3
`define TCB_STATUS_OVF_BIT 0

// Reset values and fixed top values.
`define TCB_RST_BYTE 8'h00
`define TCB_RST_WORD 16'h0000
`define TCB_MAX 16'hffff
`define TCB_TOP_8BIT 16'h00ff
`define TCB_TOP_9BIT 16'h01ff
`define TCB_TOP_10BIT 16'h03ff
`define TCB_ONE 16'h0001

`endif

// >>> verilog/tcb_pkg.sv
// Types shared by the byte-accessed 16-bit counter.
package tcb_pkg;

  // One access on the 8-bit register port; rd and wr are one-cycle strobes.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [7:0] data;
  } tcb_bus_t;

  typedef enum logic [1:0] {
    TOP_FIXED = 2'b00,
    TOP_CMPA = 2'b01,
    TOP_CAP = 2'b10
  } tcb_top_sel_t;

  typedef enum logic [1:0] {
    OVF_AT_MAX = 2'b00,
    OVF_AT_TOP = 2'b01,
    OVF_AT_BOTTOM = 2'b10
  } tcb_ovf_sel_t;

  // Counting behaviour decoded from the four waveform mode bits.
  typedef struct packed {
    tcb_top_sel_t topSel;
    logic [15:0] fixedTop;
    logic upDown;
    logic clearAtTop;
    tcb_ovf_sel_t ovfSel;
  } tcb_mode_t;

endpackage : tcb_pkg

// >>> dv/tcb_cpu_model.sv
// Behavioural CPU core that drives the counter's byte-wide register bus.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module tcb_cpu_model (
  input wire logic clock,
  input wire logic [7:0] rdData,
  output tcb_pkg::tcb_bus_t bus
);
  initial bus = '0;

  task automatic acc(input logic wr, input logic [3:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clock);
    bus <= '{wr: wr, rd: !wr, addr: a, data: d};
    @(posedge clock);
    // Idle data shows the inverse so a stale byte is never mistaken for a fresh one.
    bus <= '{wr: 1'b0, rd: 1'b0, addr: a, data: ~d};
    #1;
    q = rdData;
  endtask : acc

  // Both halves run back to back with nothing in between, as with interrupts masked.
  task automatic wr16(input logic [3:0] lo, input logic [15:0] v);
    logic [7:0] q;
    acc(1'b1, lo + 4'h1, v[15:8], q);
    acc(1'b1, lo, v[7:0], q);
  endtask : wr16

  task automatic rd16(input logic [3:0] lo, output logic [15:0] v);
    acc(1'b0, lo, 8'h00, v[7:0]);
    acc(1'b0, lo + 4'h1, 8'h00, v[15:8]);
  endtask : rd16
endmodule : tcb_cpu_model

// >>> dv/tb_top.sv
// Self-checking testbench of the byte-accessed 16-bit counter.
`timescale 1ns/1ps
`include "tcb_params.svh"
////////////////////////////////////////////////////////////////////////////////
module tb_top;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] prescaleTick = 4'h0;
  logic extTickPin = 1'b0;
  logic [7:0] rdData;
  logic [15:0] countValue;
  logic atTop;
  logic atBottom;
  logic overflowIrq;
  tcb_pkg::tcb_bus_t bus;
  int mismatches = 0;
  int checked = 0;
  logic [15:0] w;

  always #2 clock = ~clock;

  tcb_counter16 u_tcb_counter16 (.clock(clock), .reset_n(reset_n), .bus(bus), .prescaleTick(prescaleTick),
    .extTickPin(extTickPin), .rdData(rdData), .countValue(countValue), .atTop(atTop), .atBottom(atBottom),
    .overflowIrq(overflowIrq));
  tcb_cpu_model u_tcb_cpu_model (.clock(clock), .rdData(rdData), .bus(bus));

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] q;
    u_tcb_cpu_model.acc(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] q);
    u_tcb_cpu_model.acc(1'b0, a, 8'h00, q);
  endtask : rd

  task automatic tick();
    pulse(4'h1);
  endtask : tick

  // One cycle of prescaler tap pulses; only the tap picked by the select may move the counter.
  task automatic pulse(input logic [3:0] taps);
    @(posedge clock);
    prescaleTick <= taps;
    @(posedge clock);
    prescaleTick <= 4'h0;
  endtask : pulse

  // The count lands on the edge that samples the tick, so it is polled for a bounded number of cycles.
  task automatic waitCnt(input logic [15:0] e);
    for (int i = 0; i < 8 && countValue !== e; i++) begin
      @(posedge clock);
      #1;
    end
    chk(countValue, e);
    if (countValue !== e) report_and_stop();
  endtask : waitCnt

  task automatic tReset();
    chk(countValue, 16'h0000);
    chk(atBottom, 1'b1);
    chk(overflowIrq, 1'b0);
    rd(`TCB_ADDR_CNT_HI, w[7:0]);
    chk(w[7:0], 8'h00);
  endtask : tReset

  task automatic tAccess();
    u_tcb_cpu_model.wr16(`TCB_ADDR_CNT_LO, 16'h01ff);
    chk(countValue, 16'h01ff);
    // A stale holding byte makes the later read fail unless the lower-byte read reloads it.
    wr(`TCB_ADDR_CNT_HI, 8'h5a);
    chk(countValue, 16'h01ff);
    u_tcb_cpu_model.rd16(`TCB_ADDR_CNT_LO, w);
    chk(w, 16'h01ff);
  endtask : tAccess

  task automatic tHolding();
    wr(`TCB_ADDR_CNT_HI, 8'h12);
    wr(`TCB_ADDR_CNT_LO, 8'h34);
    chk(countValue, 16'h1234);
    wr(`TCB_ADDR_CMPA_LO, 8'h56);
    wr(`TCB_ADDR_CNT_HI, 8'h77);
    rd(`TCB_ADDR_CMPA_HI, w[7:0]);
    chk(w[7:0], 8'h12);
    rd(`TCB_ADDR_CMPA_HI, w[7:0]);
    chk(w[7:0], 8'h12);
    rd(`TCB_ADDR_CNT_HI, w[7:0]);
    chk(w[7:0], 8'h77);
    chk(countValue, 16'h1234);
    u_tcb_cpu_model.wr16(`TCB_ADDR_CMPB_LO, 16'h4321);
    u_tcb_cpu_model.wr16(`TCB_ADDR_CAP_LO, 16'h9abc);
    wr(`TCB_ADDR_CNT_HI, 8'h00);
    rd(`TCB_ADDR_CMPB_HI, w[7:0]);
    chk(w[7:0], 8'h43);
    u_tcb_cpu_model.rd16(`TCB_ADDR_CAP_LO, w);
    chk(w, 16'h9abc);
  endtask : tHolding

  task automatic tCount();
    wr(`TCB_ADDR_CTRL_A, 8'h00);
    wr(`TCB_ADDR_CTRL_B, 8'h02);
    u_tcb_cpu_model.wr16(`TCB_ADDR_CNT_LO, 16'hfffe);
    tick();
    waitCnt(16'hffff);
    chk(atTop, 1'b1);
    tick();
    waitCnt(16'h0000);
    chk(overflowIrq, 1'b1);
    chk(atBottom, 1'b1);
    wr(`TCB_ADDR_STATUS, 8'h01);
    chk(overflowIrq, 1'b0);
  endtask : tCount

  task automatic tStop();
    wr(`TCB_ADDR_CTRL_B, 8'h00);
    repeat (3) tick();
    repeat (4) @(posedge clock);
    #1;
    chk(countValue, 16'h0000);
    u_tcb_cpu_model.wr16(`TCB_ADDR_CNT_LO, 16'habcd);
    chk(countValue, 16'habcd);
  endtask : tStop

  task automatic tPriority();
    wr(`TCB_ADDR_CTRL_B, 8'h02);
    wr(`TCB_ADDR_CNT_HI, 8'h20);
    fork
      wr(`TCB_ADDR_CNT_LO, 8'h30);
      tick();
    join
    repeat (4) @(posedge clock);
    #1;
    chk(countValue, 16'h2030);
  endtask : tPriority

  task automatic tExternal();
    wr(`TCB_ADDR_CTRL_B, 8'h07);
    @(posedge clock);
    extTickPin <= 1'b1;
    waitCnt(16'h2031);
    wr(`TCB_ADDR_CTRL_B, 8'h06);
    @(posedge clock);
    extTickPin <= 1'b0;
    waitCnt(16'h2032);
  endtask : tExternal

  // Select 5 follows tap 3 only; select 1 counts on every cycle that it stands.
  task automatic tTaps();
    wr(`TCB_ADDR_CTRL_B, 8'h05);
    u_tcb_cpu_model.wr16(`TCB_ADDR_CNT_LO, 16'h0010);
    pulse(4'h7);
    repeat (2) @(posedge clock);
    #1;
    chk(countValue, 16'h0010);
    pulse(4'h8);
    waitCnt(16'h0011);
    wr(`TCB_ADDR_CTRL_B, 8'h01);
    wr(`TCB_ADDR_CTRL_B, 8'h00);
    repeat (4) @(posedge clock);
    #1;
    chk(countValue, 16'h0013);
  endtask : tTaps

  // Clear-at-compare mode takes its upper mode bits from control register B.
  task automatic tClear();
    u_tcb_cpu_model.wr16(`TCB_ADDR_CMPA_LO, 16'h0005);
    wr(`TCB_ADDR_CTRL_B, 8'h0a);
    u_tcb_cpu_model.wr16(`TCB_ADDR_CNT_LO, 16'h0004);
    tick();
    waitCnt(16'h0005);
    chk(atTop, 1'b1);
    tick();
    waitCnt(16'h0000);
    chk(overflowIrq, 1'b0);
  endtask : tClear

  // Modes that need the lower mode bits in control register A: clear with overflow at top, then up/down.
  task automatic tModes();
    wr(`TCB_ADDR_CTRL_A, 8'h03);
    wr(`TCB_ADDR_CTRL_B, 8'h1a);
    u_tcb_cpu_model.wr16(`TCB_ADDR_CNT_LO, 16'h0005);
    tick();
    waitCnt(16'h0000);
    chk(overflowIrq, 1'b1);
    wr(`TCB_ADDR_STATUS, 8'h01);
    chk(overflowIrq, 1'b0);
    wr(`TCB_ADDR_CTRL_A, 8'h01);
    wr(`TCB_ADDR_CTRL_B, 8'h02);
    u_tcb_cpu_model.wr16(`TCB_ADDR_CNT_LO, 16'h00fe);
    tick();
    waitCnt(16'h00ff);
    chk(atTop, 1'b1);
    tick();
    waitCnt(16'h00fe);
    u_tcb_cpu_model.wr16(`TCB_ADDR_CNT_LO, 16'h0001);
    tick();
    waitCnt(16'h0000);
    chk(atBottom, 1'b1);
    chk(overflowIrq, 1'b0);
    tick();
    waitCnt(16'h0001);
    chk(overflowIrq, 1'b1);
  endtask : tModes

  initial begin
    repeat (20) @(posedge clock);
    reset_n <= 1'b1;
    repeat (4) @(posedge clock);
    #1;
    tReset();
    tAccess();
    tHolding();
    tCount();
    tStop();
    tPriority();
    tExternal();
    tTaps();
    tClear();
    tModes();
    report_and_stop();
  end
endmodule : tb_top
